// file: hdl/nie_irq_enable_clear.sv
// interrupt enable bank of the memory controller with its flag register
// assumes events are one-cycle pulses from controller logic on hclk
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// R1 - writing zero to an enable-clear bit leaves that enable as it was
// R2 - writing one to an enable-clear bit clears only that enable
// R3 - reading enable-clear returns the present enables, not the written value
// R4 - bit 10 holds the eeprom write-completed enable
// R5 - bit 9 holds the eeprom sector overflow enable
// R6 - bit 8 holds the eeprom sector full enable
// R7 - bit 7 holds the write or erase suspended enable
// R8 - bit 6 holds the general memory error enable
// R9 - bit 5 holds the ecc dual error enable
// R10 - bits 4 to 0 hold single ecc, lock, program, address, done enables
// R11 - a disabled source no longer raises the interrupt, its flag may stay
module nie_irq_enable_clear
    import nie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [nie_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [nie_pkg::DATA_W-1:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [nie_pkg::DATA_W-1:0] hrdata,
    input wire logic write_lock,
    input wire logic [nie_pkg::IRQ_W-1:0] nvm_event,
    output logic [nie_pkg::IRQ_W-1:0] irq_enable,
    output logic [nie_pkg::IRQ_W-1:0] irq_flags,
    output logic irq
);
    import nie_pkg::*;

    // ---------------------------------------------------------------
    // decode helper
    // ---------------------------------------------------------------
    function automatic logic hits(input logic [DEC_W-1:0] addr, input logic [DEC_W-1:0] off);
        hits = (addr == off);
    endfunction

    // ---------------------------------------------------------------
    // bus front end
    // ---------------------------------------------------------------
    wire logic wr_stb;
    wire logic [DEC_W-1:0] acc_addr;
    wire logic [DATA_W-1:0] rd_value;

    nie_ahb_slave u_slave (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .rd_value(rd_value),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .wr_stb(wr_stb),
        .acc_addr(acc_addr)
    );

    // ---------------------------------------------------------------
    // write decode
    // ---------------------------------------------------------------
    wire logic hit_set;
    wire logic hit_clear;
    wire logic hit_flags;
    wire logic enable_write_ok;
    wire logic [IRQ_W-1:0] wr_bits;
    wire logic [IRQ_W-1:0] enable_set_mask;
    wire logic [IRQ_W-1:0] enable_clr_mask;
    wire logic [IRQ_W-1:0] flag_clr_mask;

    assign hit_set = hits(acc_addr, OFF_ENABLE_SET);
    assign hit_clear = hits(acc_addr, OFF_ENABLE_CLEAR);
    assign hit_flags = hits(acc_addr, OFF_FLAGS);
    assign wr_bits = hwdata[IRQ_W-1:0];
    // protected writes to the enables are dropped without error
    assign enable_write_ok = wr_stb & ~write_lock;
    assign enable_set_mask = (enable_write_ok & hit_set) ? wr_bits : NO_BITS;
    // zeros in the mask leave enables alone, ones clear them
    assign enable_clr_mask = (enable_write_ok & hit_clear) ? wr_bits : NO_BITS; // R1 R2 R10
    assign flag_clr_mask = (wr_stb & hit_flags) ? wr_bits : NO_BITS;

    // ---------------------------------------------------------------
    // enable and flag storage
    // ---------------------------------------------------------------
    wire logic [IRQ_W-1:0] enable_q;
    wire logic [IRQ_W-1:0] flag_q;

    // one flop per source, indexed by the BIT_ constants
    nie_bit_bank u_enable (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_mask(enable_set_mask),
        .clr_mask(enable_clr_mask),
        .q(enable_q)
    ); // R4 R5 R6 R7 R8 R9 R10

    // hardware events beat a software clear in the same cycle
    nie_bit_bank u_flags (
        .hclk(hclk),
        .hresetn(hresetn),
        .set_mask(nvm_event),
        .clr_mask(flag_clr_mask),
        .q(flag_q)
    );

    // ---------------------------------------------------------------
    // read selection
    // ---------------------------------------------------------------
    wire logic [REG_W-1:0] enable_word;
    wire logic [REG_W-1:0] flag_word;
    wire logic rd_hit_enable;

    assign enable_word = {RSVD_ZERO, enable_q};
    assign flag_word = {RSVD_ZERO, flag_q};
    // both set and clear views show the live enables
    assign rd_hit_enable = hits(acc_addr, OFF_ENABLE_SET) | hits(acc_addr, OFF_ENABLE_CLEAR); // R3
    assign rd_value = rd_hit_enable ? {{(DATA_W-REG_W){1'b0}}, enable_word}
                    : hits(acc_addr, OFF_FLAGS) ? {{(DATA_W-REG_W){1'b0}}, flag_word}
                    : RST_RDATA;

    // ---------------------------------------------------------------
    // interrupt output
    // ---------------------------------------------------------------
    wire logic [IRQ_W-1:0] irq_active;
    wire logic irq_next;

    assign irq_active = flag_q & enable_q; // R11
    assign irq_next = |irq_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
            irq_enable <= RST_ENABLE;
            irq_flags <= RST_FLAGS;
        end else begin
            irq <= irq_next;
            irq_enable <= enable_q;
            irq_flags <= flag_q;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    wire logic clr_write;
    wire logic rd_clear_addr;
    wire logic rd_accept;

    assign clr_write = wr_stb & hit_clear & ~write_lock;
    assign rd_clear_addr = hsel & hready & htrans[HTRANS_ACTIVE_BIT] & ~hwrite
                         & (haddr[DEC_W-1:0] == OFF_ENABLE_CLEAR);
    assign rd_accept = hsel & hready & htrans[HTRANS_ACTIVE_BIT] & ~hwrite;

    sequence s_clear_bit(int n);
        clr_write && wr_bits[n];
    endsequence

    sequence s_read_clear;
        rd_clear_addr ##1 !hreadyout;
    endsequence

    sequence s_keep_bit(int n);
        clr_write && !wr_bits[n] && enable_q[n];
    endsequence

    sequence s_read_at(logic [DEC_W-1:0] off);
        rd_accept && (haddr[DEC_W-1:0] == off) ##1 !hreadyout;
    endsequence

    property p_zero_keeps;
        @(posedge hclk) disable iff (!hresetn)
        clr_write |=> ((enable_q ^ $past(enable_q)) & ~$past(wr_bits)) == NO_BITS;
    endproperty
    a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed an enable"); // R1

    property p_one_clears;
        @(posedge hclk) disable iff (!hresetn)
        clr_write |=> (enable_q == ($past(enable_q) & ~$past(wr_bits)));
    endproperty
    a_one_clears: assert property (p_one_clears) else $error("enable clear wrong"); // R2

    property p_read_live;
        @(posedge hclk) disable iff (!hresetn)
        s_read_clear |=> hreadyout && (hrdata[IRQ_W-1:0] == $past(enable_q))
                         && (hrdata[DATA_W-1:IRQ_W] == '0);
    endproperty
    a_read_live: assert property (p_read_live) else $error("read does not show enables"); // R3

    property p_write_completed;
        @(posedge hclk) disable iff (!hresetn)
        s_clear_bit(BIT_EEPROM_WRITE_COMPLETED) |=> !enable_q[BIT_EEPROM_WRITE_COMPLETED] ##1
            irq_enable[BIT_EEPROM_WRITE_COMPLETED] == 1'b0 || $past(enable_set_mask[BIT_EEPROM_WRITE_COMPLETED]);
    endproperty
    a_write_completed: assert property (p_write_completed) else $error("bit 10 not cleared"); // R4

    property p_sector_overflow;
        @(posedge hclk) disable iff (!hresetn)
        s_clear_bit(BIT_EEPROM_SECTOR_OVERFLOW) |=> !enable_q[BIT_EEPROM_SECTOR_OVERFLOW];
    endproperty
    a_sector_overflow: assert property (p_sector_overflow) else $error("bit 9 not cleared"); // R5

    property p_sector_full;
        @(posedge hclk) disable iff (!hresetn)
        s_clear_bit(BIT_EEPROM_SECTOR_FULL) |=> !enable_q[BIT_EEPROM_SECTOR_FULL];
    endproperty
    a_sector_full: assert property (p_sector_full) else $error("bit 8 not cleared"); // R6

    property p_suspended;
        @(posedge hclk) disable iff (!hresetn)
        s_clear_bit(BIT_WRITE_ERASE_SUSPENDED) |=> !enable_q[BIT_WRITE_ERASE_SUSPENDED];
    endproperty
    a_suspended: assert property (p_suspended) else $error("bit 7 not cleared"); // R7

    property p_memory_error;
        @(posedge hclk) disable iff (!hresetn)
        s_clear_bit(BIT_MEMORY_ERROR) |=> !enable_q[BIT_MEMORY_ERROR];
    endproperty
    a_memory_error: assert property (p_memory_error) else $error("bit 6 not cleared"); // R8

    property p_dual_error;
        @(posedge hclk) disable iff (!hresetn)
        s_clear_bit(BIT_ECC_DUAL_ERROR) |=> !enable_q[BIT_ECC_DUAL_ERROR];
    endproperty
    a_dual_error: assert property (p_dual_error) else $error("bit 5 not cleared"); // R9

    property p_low_bits;
        @(posedge hclk) disable iff (!hresetn)
        clr_write |=> (enable_q[BIT_ECC_SINGLE_ERROR:BIT_OPERATION_DONE]
                      & $past(wr_bits[BIT_ECC_SINGLE_ERROR:BIT_OPERATION_DONE])) == '0;
    endproperty
    a_low_bits: assert property (p_low_bits) else $error("low enable not cleared"); // R10

    property p_disabled_quiet;
        @(posedge hclk) disable iff (!hresetn)
        (irq_active == NO_BITS) |=> !irq;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("irq from disabled source"); // R11

    property p_enabled_raises;
        @(posedge hclk) disable iff (!hresetn)
        (irq_active != NO_BITS) |=> irq;
    endproperty
    a_enabled_raises: assert property (p_enabled_raises) else $error("enabled flag gave no irq"); // R11

    property p_flag_survives;
        @(posedge hclk) disable iff (!hresetn)
        (clr_write && (flag_q != NO_BITS) && !(wr_stb && hit_flags)) |=> (flag_q & $past(flag_q)) == $past(flag_q);
    endproperty
    a_flag_survives: assert property (p_flag_survives) else $error("enable clear touched a flag"); // R11

    property p_fall_only_by_clear;
        @(posedge hclk) disable iff (!hresetn)
        !clr_write |=> ($past(enable_q) & ~enable_q) == NO_BITS;
    endproperty
    a_fall_only_by_clear: assert property (p_fall_only_by_clear) else $error("enable fell without clear"); // R1

    property p_keep_write_completed;
        @(posedge hclk) disable iff (!hresetn)
        s_keep_bit(BIT_EEPROM_WRITE_COMPLETED) |=> enable_q[BIT_EEPROM_WRITE_COMPLETED];
    endproperty
    a_keep_write_completed: assert property (p_keep_write_completed) else $error("bit 10 lost on zero"); // R4

    property p_keep_sector_overflow;
        @(posedge hclk) disable iff (!hresetn)
        s_keep_bit(BIT_EEPROM_SECTOR_OVERFLOW) |=> enable_q[BIT_EEPROM_SECTOR_OVERFLOW];
    endproperty
    a_keep_sector_overflow: assert property (p_keep_sector_overflow) else $error("bit 9 lost on zero"); // R5

    property p_keep_sector_full;
        @(posedge hclk) disable iff (!hresetn)
        s_keep_bit(BIT_EEPROM_SECTOR_FULL) |=> enable_q[BIT_EEPROM_SECTOR_FULL];
    endproperty
    a_keep_sector_full: assert property (p_keep_sector_full) else $error("bit 8 lost on zero"); // R6

    property p_keep_suspended;
        @(posedge hclk) disable iff (!hresetn)
        s_keep_bit(BIT_WRITE_ERASE_SUSPENDED) |=> enable_q[BIT_WRITE_ERASE_SUSPENDED];
    endproperty
    a_keep_suspended: assert property (p_keep_suspended) else $error("bit 7 lost on zero"); // R7

    property p_keep_memory_error;
        @(posedge hclk) disable iff (!hresetn)
        s_keep_bit(BIT_MEMORY_ERROR) |=> enable_q[BIT_MEMORY_ERROR];
    endproperty
    a_keep_memory_error: assert property (p_keep_memory_error) else $error("bit 6 lost on zero"); // R8

    property p_keep_dual_error;
        @(posedge hclk) disable iff (!hresetn)
        s_keep_bit(BIT_ECC_DUAL_ERROR) |=> enable_q[BIT_ECC_DUAL_ERROR];
    endproperty
    a_keep_dual_error: assert property (p_keep_dual_error) else $error("bit 5 lost on zero"); // R9

    property p_keep_low_bits;
        @(posedge hclk) disable iff (!hresetn)
        clr_write |=> (~enable_q[BIT_ECC_SINGLE_ERROR:BIT_OPERATION_DONE]
                      & $past(enable_q[BIT_ECC_SINGLE_ERROR:BIT_OPERATION_DONE])
                      & ~$past(wr_bits[BIT_ECC_SINGLE_ERROR:BIT_OPERATION_DONE])) == '0;
    endproperty
    a_keep_low_bits: assert property (p_keep_low_bits) else $error("low enable lost on zero"); // R10

    property p_read_one_wait;
        @(posedge hclk) disable iff (!hresetn)
        rd_accept |=> !hreadyout ##1 hreadyout;
    endproperty
    a_read_one_wait: assert property (p_read_one_wait) else $error("read wait state wrong"); // R3

    property p_read_set_view;
        @(posedge hclk) disable iff (!hresetn)
        s_read_at(OFF_ENABLE_SET) |=> hrdata[IRQ_W-1:0] == $past(enable_q);
    endproperty
    a_read_set_view: assert property (p_read_set_view) else $error("set view does not show enables"); // R3

    property p_enable_mirror;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> irq_enable == $past(enable_q);
    endproperty
    a_enable_mirror: assert property (p_enable_mirror) else $error("enable port not a copy"); // R3

    property p_flag_sticky;
        @(posedge hclk) disable iff (!hresetn)
        (flag_q != NO_BITS) && !(wr_stb && hit_flags) |=> (flag_q & $past(flag_q)) == $past(flag_q);
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped without clear"); // R11

    property p_event_sets;
        @(posedge hclk) disable iff (!hresetn)
        (nvm_event != NO_BITS) |=> (flag_q & $past(nvm_event)) == $past(nvm_event);
    endproperty
    a_event_sets: assert property (p_event_sets) else $error("event did not set its flag"); // R11

    property p_flags_mirror;
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> irq_flags == $past(flag_q);
    endproperty
    a_flags_mirror: assert property (p_flags_mirror) else $error("flag port not a copy"); // R11

    property p_no_enable_no_irq;
        @(posedge hclk) disable iff (!hresetn)
        (enable_q == NO_BITS) |=> !irq;
    endproperty
    a_no_enable_no_irq: assert property (p_no_enable_no_irq) else $error("irq with all enables off"); // R11

endmodule
`default_nettype wire

// file: hdl/nie_pkg.sv
// constants for the interrupt-enable register block of the memory controller
// assumes a single AHB-Lite slave on a 32-bit bus, one clock hclk
package nie_pkg;

    // ---------------------------------------------------------------
    // bus and register geometry
    // ---------------------------------------------------------------
    localparam int DATA_W = 32;
    localparam int ADDR_W = 32;
    localparam int DEC_W = 8;
    localparam int REG_W = 16;
    localparam int IRQ_W = 11;

    // word offsets of the register bank
    localparam logic [DEC_W-1:0] OFF_ENABLE_SET = 8'h08;
    localparam logic [DEC_W-1:0] OFF_ENABLE_CLEAR = 8'h0C;
    localparam logic [DEC_W-1:0] OFF_FLAGS = 8'h10;

    localparam logic [IRQ_W-1:0] RST_ENABLE = 11'h000;
    localparam logic [IRQ_W-1:0] RST_FLAGS = 11'h000;
    localparam logic [IRQ_W-1:0] NO_BITS = 11'h000;
    localparam logic [DATA_W-1:0] RST_RDATA = 32'h00000000;
    localparam logic [DEC_W-1:0] RST_ADDR = 8'h00;
    localparam logic [REG_W-IRQ_W-1:0] RSVD_ZERO = 5'h00;

    // ---------------------------------------------------------------
    // interrupt source positions
    // ---------------------------------------------------------------
    localparam int BIT_OPERATION_DONE = 0;
    localparam int BIT_ADDRESS_ERROR = 1;
    localparam int BIT_PROGRAM_ERROR = 2;
    localparam int BIT_LOCK_ERROR = 3;
    localparam int BIT_ECC_SINGLE_ERROR = 4;
    localparam int BIT_ECC_DUAL_ERROR = 5;
    localparam int BIT_MEMORY_ERROR = 6;
    localparam int BIT_WRITE_ERASE_SUSPENDED = 7;
    localparam int BIT_EEPROM_SECTOR_FULL = 8;
    localparam int BIT_EEPROM_SECTOR_OVERFLOW = 9;
    localparam int BIT_EEPROM_WRITE_COMPLETED = 10;

    // ---------------------------------------------------------------
    // AHB-Lite encodings
    // ---------------------------------------------------------------
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

endpackage

// file: hdl/nie_bit_bank.sv
// one row of independently set and cleared flip-flops
// assumes set and clear masks come from logic on hclk; set wins over clear
`timescale 1ns/100ps
`default_nettype none
module nie_bit_bank
    import nie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [nie_pkg::IRQ_W-1:0] set_mask,
    input wire logic [nie_pkg::IRQ_W-1:0] clr_mask,
    output logic [nie_pkg::IRQ_W-1:0] q
);
    import nie_pkg::*;

    genvar i;
    generate
        for (i = 0; i < IRQ_W; i++) begin : g_bit
            wire logic bit_next;
            // a set arriving with a clear is kept
            assign bit_next = set_mask[i] | (q[i] & ~clr_mask[i]);
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    q[i] <= RST_ENABLE[i];
                end else begin
                    q[i] <= bit_next;
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

// file: hdl/nie_ahb_slave.sv
// AHB-Lite slave front end: address capture, write strobe, registered read data
// assumes a single slave whose hreadyout is the bus hready
`timescale 1ns/100ps
`default_nettype none
module nie_ahb_slave
    import nie_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [nie_pkg::ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [nie_pkg::DATA_W-1:0] rd_value,
    output logic hreadyout,
    output logic hresp,
    output logic [nie_pkg::DATA_W-1:0] hrdata,
    output logic wr_stb,
    output logic [nie_pkg::DEC_W-1:0] acc_addr
);
    import nie_pkg::*;

    wire logic accept;
    wire logic accept_rd;
    logic rd_pend_reg;

    assign accept = hsel & hready & htrans[HTRANS_ACTIVE_BIT];
    assign accept_rd = accept & ~hwrite;

    // reads take one wait state so data written just before is seen
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_stb <= 1'b0;
            rd_pend_reg <= 1'b0;
            acc_addr <= RST_ADDR;
            hreadyout <= 1'b1;
            hresp <= HRESP_OKAY;
            hrdata <= RST_RDATA;
        end else begin
            wr_stb <= accept & hwrite;
            rd_pend_reg <= accept_rd;
            hreadyout <= ~accept_rd;
            hresp <= HRESP_OKAY;
            if (accept) begin
                acc_addr <= haddr[DEC_W-1:0];
            end
            if (rd_pend_reg) begin
                hrdata <= rd_value;
            end
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_nvm_irq_enable_clear.sv
// self-checking bench for the interrupt enable bank, driven over AHB-Lite
// assumes the design top nie_irq_enable_clear and package nie_pkg from hdl/
`timescale 1ns/100ps
`default_nettype none
module tb_nvm_irq_enable_clear;
    import nie_pkg::*;

    // ---------------------------------------------------------------
    // signals and instance
    // ---------------------------------------------------------------
    localparam logic [31:0] A_SET = {24'h000000, OFF_ENABLE_SET};
    localparam logic [31:0] A_CLR = {24'h000000, OFF_ENABLE_CLEAR};
    localparam logic [31:0] A_FLG = {24'h000000, OFF_FLAGS};
    localparam logic [31:0] A_NONE = 32'h00000020;
    localparam logic [31:0] ALL = 32'h000007FF;
    logic hclk;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [31:0] hwdata;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic write_lock;
    logic [10:0] nvm_event;
    logic [10:0] irq_enable;
    logic [10:0] irq_flags;
    logic irq;
    int n_mismatch;
    int checks;

    nie_irq_enable_clear dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .write_lock(write_lock),
        .nvm_event(nvm_event), .irq_enable(irq_enable), .irq_flags(irq_flags), .irq(irq)
    );

    always #5 hclk = ~hclk;

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 20) begin
            n++;
            @(posedge hclk);
        end
        if (n >= 20) n_mismatch++;
    endtask

    task automatic xfer(input logic [31:0] a, input logic wr, input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        xfer(a, 1'b1, d, dummy);
    endtask

    task automatic rd_check(input string name, input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] v;
        xfer(a, 1'b0, 32'h00000000, v);
        check(name, v, exp);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_reset();
        #1;
        check("irq_enable rst", {21'h0, irq_enable}, 32'h0);
        check("irq_flags rst", {21'h0, irq_flags}, 32'h0);
        check("irq rst", {31'h0, irq}, 32'h0);
        rd_check("clear reg rst", A_CLR, 32'h0);
        rd_check("flags rst", A_FLG, 32'h0);
    endtask

    task automatic t_clear_each();
        logic [31:0] exp;
        for (int i = 0; i < 11; i++) begin
            wr(A_SET, ALL);
            wr(A_CLR, 32'h1 << i);
            exp = ALL & ~(32'h1 << i);
            rd_check("clear one bit", A_CLR, exp);
            #1;
            check("irq_enable port", {21'h0, irq_enable}, exp);
        end
    endtask

    task automatic t_zero_write();
        wr(A_SET, ALL);
        wr(A_CLR, 32'h00000000);
        rd_check("zero write", A_CLR, ALL);
        wr(A_CLR, 32'hFFFFF800);
        rd_check("upper bits write", A_CLR, ALL);
        wr(A_CLR, 32'h00000421);
        rd_check("read present state", A_CLR, 32'h000003DE);
        rd_check("set view agrees", A_SET, 32'h000003DE);
    endtask

    task automatic t_irq();
        wr(A_CLR, ALL);
        wr(A_SET, 32'h1 << BIT_ECC_DUAL_ERROR);
        @(posedge hclk);
        nvm_event <= 11'h021;
        @(posedge hclk);
        nvm_event <= 11'h000;
        repeat (2) @(posedge hclk);
        #1;
        check("irq raised", {31'h0, irq}, 32'h1);
        check("flags set", {21'h0, irq_flags}, 32'h021);
        wr(A_CLR, 32'h00000020);
        repeat (3) @(posedge hclk);
        #1;
        check("irq after clear", {31'h0, irq}, 32'h0);
        check("flag kept", {21'h0, irq_flags}, 32'h021);
        rd_check("flags read", A_FLG, 32'h00000021);
        wr(A_FLG, 32'h00000021);
        rd_check("flags cleared", A_FLG, 32'h0);
    endtask

    task automatic t_lock_unmapped();
        wr(A_SET, ALL);
        write_lock <= 1'b1;
        wr(A_CLR, ALL);
        rd_check("locked clear", A_CLR, ALL);
        write_lock <= 1'b0;
        wr(A_NONE, 32'hFFFFFFFF);
        rd_check("unmapped read", A_NONE, 32'h0);
        rd_check("unmapped write", A_CLR, ALL);
        wr(A_CLR, ALL);
        rd_check("unlocked clear", A_CLR, 32'h0);
    endtask

    task automatic t_collide();
        wr(A_CLR, ALL);
        write_lock <= 1'b1;
        wr(A_SET, ALL);
        write_lock <= 1'b0;
        rd_check("locked set", A_SET, 32'h0);
        wr(A_SET, 32'h1 << BIT_EEPROM_WRITE_COMPLETED);
        nvm_event <= 11'h400;
        wr(A_FLG, 32'h00000400);
        nvm_event <= 11'h000;
        rd_check("event beats clear", A_FLG, 32'h00000400);
        #1;
        check("irq on bit 10", {31'h0, irq}, 32'h1);
        wr(A_CLR, 32'h00000400);
        repeat (2) @(posedge hclk);
        #1;
        check("irq bit 10 off", {31'h0, irq}, 32'h0);
        rd_check("flag 10 kept", A_FLG, 32'h00000400);
        wr(A_FLG, 32'h00000400);
        rd_check("flag 10 cleared", A_FLG, 32'h0);
    endtask

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #50000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        n_mismatch = 0;
        checks = 0;
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        write_lock = 1'b0;
        nvm_event = 11'h000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_clear_each();
        t_zero_write();
        t_irq();
        t_lock_unmapped();
        t_collide();
        complete_run();
    end
endmodule
`default_nettype wire
